// File: sadc_defines.vh
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

// ==========================================
// Register offsets
`define SADC_OFF_CTRL0   3'h0
`define SADC_OFF_CTRL1   3'h1
`define SADC_OFF_RESH    3'h2
`define SADC_OFF_RESL    3'h3
`define SADC_OFF_STATUS  3'h4
`define SADC_OFF_MASK    3'h5

// ==========================================
// Field positions
`define SADC_C0_CLKLO_HI  7
`define SADC_C0_CLKLO_LO  6
`define SADC_C0_CHAN_HI   5
`define SADC_C0_CHAN_LO   3
`define SADC_C0_GO        2
`define SADC_C0_POWER     0
`define SADC_C1_JUSTIFY   7
`define SADC_C1_CLKHI     6
`define SADC_C1_PCFG_HI   3
`define SADC_C1_PCFG_LO   0
`define SADC_C0_WMASK     8'hfd
`define SADC_C1_WMASK     8'hcf

// ==========================================
// Reset values
`define SADC_CTRL0_RST    8'h00
`define SADC_CTRL1_RST    8'h00
`define SADC_RES_RST      8'h00

// ==========================================
// Timing
`define SADC_CONV_TAD     4'hc
`define SADC_RC_DIV       7'h64
`define SADC_RC_TAD_NS    4000
`define SADC_CLK_NS       40

`endif

// File: sadc_top.v
`include "sadc_defines.vh"

module sadc_top (
    input  wire       ref_clk,
    input  wire       rstn,
    input  wire [2:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output wire       irq,
    input  wire       cmp_above,
    output reg  [9:0] dac_code,
    output reg        sample_hold,
    output reg  [2:0] chan_sel,
    output reg        analog_power,
    output reg  [7:0] analog_pin_en,
    output reg        vref_pos_ext,
    output reg        vref_neg_ext
);

// ==========================================
// Reset release
reg        rst_s1_reg;
reg        rst_s2_reg;
wire       rst_n = rst_s2_reg;

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        rst_s1_reg <= 1'b0;
        rst_s2_reg <= 1'b0;
    end else begin
        rst_s1_reg <= 1'b1;
        rst_s2_reg <= rst_s1_reg;
    end
end

// ==========================================
// Comparator input synchroniser
reg        cmp_s1_reg;
reg        cmp_s2_reg;
reg        cmp_s3_reg;
reg        cmp_reg;

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        cmp_s1_reg <= 1'b0;
        cmp_s2_reg <= 1'b0;
        cmp_s3_reg <= 1'b0;
        cmp_reg    <= 1'b0;
    end else begin
        cmp_s1_reg <= cmp_above;
        cmp_s2_reg <= cmp_s1_reg;
        cmp_s3_reg <= cmp_s2_reg;
        if (cmp_s2_reg == cmp_s3_reg) begin
            cmp_reg <= cmp_s3_reg;
        end
    end
end

// ==========================================
// Registers
reg  [7:0] ctrl0_reg;
reg  [7:0] ctrl1_reg;
reg  [7:0] resh_reg;
reg  [7:0] resl_reg;
reg        status_reg;
reg        mask_reg;
reg        busy_reg;
reg  [9:0] sar_reg;
reg  [3:0] bit_cnt_reg;
reg  [6:0] div_cnt_reg;
reg        done_pulse;

wire [2:0] clk_sel = {ctrl1_reg[`SADC_C1_CLKHI], ctrl0_reg[`SADC_C0_CLKLO_HI:`SADC_C0_CLKLO_LO]};
wire       power   = ctrl0_reg[`SADC_C0_POWER];
wire       wr_c0   = reg_wr && (reg_addr == `SADC_OFF_CTRL0);
wire       rd_st   = reg_rd && (reg_addr == `SADC_OFF_STATUS);
wire       abort_wr = wr_c0 && (!reg_wdata[`SADC_C0_GO] || !reg_wdata[`SADC_C0_POWER]);

// Divide ratio for the selected bit clock
function [6:0] sadc_div;
    input [2:0] sel;
    begin
        case (sel)
            3'h0:    sadc_div = 7'h02;
            3'h1:    sadc_div = 7'h08;
            3'h2:    sadc_div = 7'h20;
            3'h4:    sadc_div = 7'h04;
            3'h5:    sadc_div = 7'h10;
            3'h6:    sadc_div = 7'h40;
            default: sadc_div = `SADC_RC_DIV;
        endcase
    end
endfunction

// Justified result bytes
function [15:0] sadc_just;
    input       right;
    input [9:0] val;
    begin
        if (right) begin
            sadc_just = {6'h00, val};
        end else begin
            sadc_just = {val, 6'h00};
        end
    end
endfunction

// ==========================================
// Bit clock divider
// Comparator path takes about six cycles, so shorter bit periods give a meaningless result
wire [6:0] div_top = sadc_div(clk_sel) - 7'h01;
wire       tad_en  = busy_reg && (div_cnt_reg >= div_top);

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        div_cnt_reg <= 7'h00;
    end else if (!busy_reg || tad_en) begin
        div_cnt_reg <= 7'h00;
    end else begin
        div_cnt_reg <= div_cnt_reg + 7'h01;
    end
end

// ==========================================
// Control, conversion, results
wire [15:0] just_res = sadc_just(ctrl1_reg[`SADC_C1_JUSTIFY], sar_reg);

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        ctrl0_reg   <= `SADC_CTRL0_RST;
        ctrl1_reg   <= `SADC_CTRL1_RST;
        resh_reg    <= `SADC_RES_RST;
        resl_reg    <= `SADC_RES_RST;
        busy_reg    <= 1'b0;
        sar_reg     <= 10'h000;
        bit_cnt_reg <= 4'h0;
        done_pulse  <= 1'b0;
        mask_reg    <= 1'b0;
    end else begin
        done_pulse <= 1'b0;
        if (wr_c0) begin
            ctrl0_reg <= reg_wdata & `SADC_C0_WMASK;
            if (reg_wdata[`SADC_C0_GO] && reg_wdata[`SADC_C0_POWER] && power && !busy_reg) begin
                busy_reg    <= 1'b1;
                sar_reg     <= 10'h200;
                bit_cnt_reg <= 4'h0;
            end else if (!reg_wdata[`SADC_C0_GO] || !reg_wdata[`SADC_C0_POWER]) begin
                busy_reg <= 1'b0;
                ctrl0_reg[`SADC_C0_GO] <= 1'b0;
            end
            if (!power || busy_reg == 1'b0 && !reg_wdata[`SADC_C0_POWER]) begin
                ctrl0_reg[`SADC_C0_GO] <= reg_wdata[`SADC_C0_GO] & power & reg_wdata[`SADC_C0_POWER];
            end
        end
        // Only a CTRL0 write that aborts the conversion swallows the tick of its bit period
        if (tad_en && !abort_wr) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg >= 4'h1 && bit_cnt_reg <= 4'ha) begin
                // Keep or drop trial bit, try next one
                sar_reg[4'ha - bit_cnt_reg] <= cmp_reg;
                if (bit_cnt_reg != 4'ha) begin
                    sar_reg[4'h9 - bit_cnt_reg] <= 1'b1;
                end
            end
            if (bit_cnt_reg == `SADC_CONV_TAD - 4'h1) begin
                busy_reg               <= 1'b0;
                ctrl0_reg[`SADC_C0_GO] <= 1'b0;
                resh_reg               <= just_res[15:8];
                resl_reg               <= just_res[7:0];
                done_pulse             <= 1'b1;
            end
        end
        if (reg_wr && reg_addr == `SADC_OFF_CTRL1) begin
            ctrl1_reg <= reg_wdata & `SADC_C1_WMASK;
        end
        if (reg_wr && reg_addr == `SADC_OFF_RESH && !busy_reg) begin
            resh_reg <= reg_wdata;
        end
        if (reg_wr && reg_addr == `SADC_OFF_RESL && !busy_reg) begin
            resl_reg <= reg_wdata;
        end
        if (reg_wr && reg_addr == `SADC_OFF_MASK) begin
            mask_reg <= reg_wdata[0];
        end
    end
end

// ==========================================
// Done flag, set wins over read clear
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        status_reg <= 1'b0;
    end else if (done_pulse) begin
        status_reg <= 1'b1;
    end else if (rd_st) begin
        status_reg <= 1'b0;
    end
end

assign irq = status_reg & mask_reg;

// ==========================================
// Read port
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        case (reg_addr)
            `SADC_OFF_CTRL0:  reg_rdata <= ctrl0_reg;
            `SADC_OFF_CTRL1:  reg_rdata <= ctrl1_reg;
            `SADC_OFF_RESH:   reg_rdata <= resh_reg;
            `SADC_OFF_RESL:   reg_rdata <= resl_reg;
            `SADC_OFF_STATUS: reg_rdata <= {7'h00, status_reg};
            `SADC_OFF_MASK:   reg_rdata <= {7'h00, mask_reg};
            default:          reg_rdata <= 8'h00;
        endcase
    end else begin
        reg_rdata <= 8'h00;
    end
end

// ==========================================
// Pin map and references
wire [3:0] pcfg = ctrl1_reg[`SADC_C1_PCFG_HI:`SADC_C1_PCFG_LO];
reg  [7:0] pin_next;
reg  [1:0] ref_next;

// Analog pins per configuration code
always @* begin
    case (pcfg)
        4'h0:    pin_next = 8'hff;
        4'h1:    pin_next = 8'hf7;
        4'h2:    pin_next = 8'h1f;
        4'h3:    pin_next = 8'h17;
        4'h4:    pin_next = 8'h0b;
        4'h5:    pin_next = 8'h03;
        4'h6:    pin_next = 8'h00;
        4'h7:    pin_next = 8'h00;
        4'h8:    pin_next = 8'hf3;
        4'h9:    pin_next = 8'h3f;
        4'ha:    pin_next = 8'h37;
        4'hb:    pin_next = 8'h33;
        4'hc:    pin_next = 8'h13;
        4'hd:    pin_next = 8'h03;
        4'he:    pin_next = 8'h01;
        default: pin_next = 8'h01;
    endcase
end

// External references, positive on pin 3, negative on pin 2
always @* begin
    case (pcfg)
        4'h1:    ref_next = 2'b10;
        4'h3:    ref_next = 2'b10;
        4'h5:    ref_next = 2'b10;
        4'ha:    ref_next = 2'b10;
        4'h8:    ref_next = 2'b11;
        4'hb:    ref_next = 2'b11;
        4'hc:    ref_next = 2'b11;
        4'hd:    ref_next = 2'b11;
        4'hf:    ref_next = 2'b11;
        default: ref_next = 2'b00;
    endcase
end

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        analog_pin_en <= 8'hff;
        vref_pos_ext  <= 1'b0;
        vref_neg_ext  <= 1'b0;
        chan_sel      <= 3'h0;
        analog_power  <= 1'b0;
        dac_code      <= 10'h000;
        sample_hold   <= 1'b0;
    end else begin
        analog_pin_en <= pin_next;
        vref_pos_ext  <= ref_next[1];
        vref_neg_ext  <= ref_next[0];
        chan_sel      <= ctrl0_reg[`SADC_C0_CHAN_HI:`SADC_C0_CHAN_LO];
        analog_power  <= power;
        dac_code      <= sar_reg;
        sample_hold   <= busy_reg;
    end
end

endmodule // sadc_top

// File: sadc_ain_model.sv
module sadc_ain_model (
    input  wire       ref_clk,
    input  wire [9:0] dac_code,
    input  wire       sample_hold,
    input  wire [2:0] chan_sel,
    input  wire       analog_power,
    output logic      cmp_above
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tgl = 1'b0;
    always @(posedge ref_clk) tgl <= ~tgl;
    // Level per channel, all eight inputs present; output toggles while not sampling
    assign cmp_above = (analog_power && sample_hold) ? ({chan_sel, 7'h4d} >= dac_code) : tgl;
endmodule // sadc_ain_model

// File: sadc_top_properties.sv
module sadc_top_props (
    input wire       ref_clk,
    input wire       rstn,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire       irq,
    input wire       sample_hold,
    input wire       analog_power,
    input wire [7:0] analog_pin_en
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0]  sel_q;
    logic        mask_q;
    logic [10:0] cnt;
    logic [10:0] span;
    // ==========
    // Shadow of clock select and mask
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sel_q <= 3'h0;
            mask_q <= 1'b0;
            cnt <= 11'h000;
        end else begin
            if (reg_wr && reg_addr == 3'h0) sel_q[1:0] <= reg_wdata[7:6];
            if (reg_wr && reg_addr == 3'h1) sel_q[2] <= reg_wdata[6];
            if (reg_wr && reg_addr == 3'h5) mask_q <= reg_wdata[0];
            cnt <= sample_hold ? cnt + 11'h001 : 11'h000;
        end
    end
    assign span = (&sel_q[1:0]) ? 11'h4b0 : 11'h018 << ({1'b0, sel_q[1:0], 1'b0} + {3'h0, sel_q[2]});
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence wr0_s; reg_wr && reg_addr == 3'h0; endsequence
    sequence done_s; $fell(sample_hold) && !$past(reg_wr, 2); endsequence
    chk_power_write: assert property (wr0_s |=> ##1 analog_power == $past(reg_wdata[0], 2))
        else $error("power bit lost");
    chk_reset_state: assert property ($rose(rstn) |-> analog_pin_en == 8'hff && !analog_power)
        else $error("bad reset state");
    chk_busy_power: assert property (sample_hold |-> analog_power)
        else $error("busy while off");
    chk_conv_span: assert property (done_s |-> cnt == span)
        else $error("bad conversion length");
    chk_done_irq: assert property (done_s ##0 mask_q |-> ##[0:2] irq)
        else $error("no interrupt");
    chk_irq_masked: assert property (irq |-> mask_q)
        else $error("masked interrupt");
    chk_irq_sticky: assert property (irq && !(reg_rd && reg_addr == 3'h4) && !reg_wr |=> irq)
        else $error("interrupt dropped");
    chk_status_clear: assert property (reg_rd && reg_addr == 3'h4 && !sample_hold && !$past(sample_hold) |=> !irq)
        else $error("status kept");
endmodule // sadc_top_props

bind sadc_top sadc_top_props chk_u (.*);

// File: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    wire  [7:0]  reg_rdata;
    wire  [7:0]  analog_pin_en;
    wire  [9:0]  dac_code;
    wire  [2:0]  chan_sel;
    wire         irq, cmp_above, sample_hold, analog_power, vref_pos_ext, vref_neg_ext;
    int          n_mismatch = 0;
    int          num_checks = 0;
    logic [7:0]  v;
    logic [9:0]  r;
    logic [15:0] vp = 16'hbd2a;
    logic [15:0] vn = 16'hb900;
    logic [7:0]  pins [16] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00, 8'h00,
                               8'hf3, 8'h3f, 8'h37, 8'h33, 8'h13, 8'h03, 8'h01, 8'h01};
    always #20 ref_clk = ~ref_clk;
    sadc_top dut_u (.*);
    sadc_ain_model model_u (.*);
    // ==========
    // Bus tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 1000; k++) begin
            rd(3'h0);
            if (v[2] === 1'b0)
                return;
        end
        n_mismatch++;
        test_done();
    endtask
    // ==========
    // Sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        for (int a = 0; a < 7; a++) begin
            rd(a[2:0]);
            chk(v, 8'h00);
        end
        chk(analog_pin_en, 8'hff);
        wr(3'h0, 8'hff);
        rd(3'h0);
        chk(v, 8'hf9);
        for (int c = 0; c < 16; c++) begin
            wr(3'h1, {4'h0, c[3:0]});
            @(negedge ref_clk);
            chk(analog_pin_en & ~{4'h0, vp[c], vn[c], 2'h0}, pins[c]);
            chk({6'h00, vref_pos_ext, vref_neg_ext}, {6'h00, vp[c], vn[c]});
        end
        for (int i = 0; i < 8; i++) begin
            r = {i[2:0], 7'h4d};
            wr(3'h5, {7'h00, i[1]});
            wr(3'h1, {i[0], i[2], 6'h00});
            wr(3'h0, {i[1:0], i[2:0], 3'h1});
            wr(3'h0, {i[1:0], i[2:0], 3'h5});
            rd(3'h0);
            chk(v, {i[1:0], i[2:0], 3'h5});
            wait_idle();
            chk({7'h00, irq}, {7'h00, i[1]});
            rd(3'h4);
            chk(v, 8'h01);
            rd(3'h4);
            chk({v[6:0], irq}, 8'h00);
            // Bit periods of two and four cycles outrun the comparator path
            if (i[1:0] != 2'b00) begin
                rd(3'h2);
                chk(v, i[0] ? {6'h00, r[9:8]} : r[9:2]);
                rd(3'h3);
                chk(v, i[0] ? r[7:0] : {r[1:0], 6'h00});
            end
            repeat (200) @(posedge ref_clk);
        end
        wr(3'h0, 8'hfd);
        wr(3'h0, 8'hf9);
        rd(3'h0);
        chk(v, 8'hf9);
        repeat (200) @(posedge ref_clk);
        rd(3'h3);
        chk(v, 8'hcd);
        rd(3'h4);
        chk(v, 8'h00);
        wr(3'h1, 8'h06);
        @(negedge ref_clk);
        chk(analog_pin_en, 8'h00);
        wr(3'h0, 8'hfd);
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(3'h0);
        chk(v, 8'h00);
        chk(analog_pin_en, 8'hff);
        test_done();
    end
endmodule // tb
